// ===== sebf_bit_capture.sv
// serial clock domain: takes one data bit per clock rising edge
`timescale 1ns/1ps
`include "sebf_params.svh"

module sebf_bit_capture (
   input  wire logic  scl,
   input  wire logic  arst_n,
   input  wire logic  sda_in,
   sebf_bit_if.cap    bit_o
);

   sebf_pkg::sebf_cap_t cur_r;
   sebf_pkg::sebf_cap_t cur_nxt;

   // level sampled while clock is high, toggle marks the new bit
   always_comb begin
      cur_nxt     = cur_r;
      cur_nxt.val = sda_in;
      cur_nxt.tgl = ~cur_r.tgl;
   end

   // clock stops between frames, so nothing here waits for an edge
   always_ff @(posedge scl or negedge arst_n) begin
      if (!arst_n) begin
         cur_r <= '0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // value holds a full clock period, long enough for the toggle to cross
   assign bit_o.bit_val = cur_r.val;
   assign bit_o.bit_tgl = cur_r.tgl;

endmodule : sebf_bit_capture

// ===== sebf_front_end.sv
// two-wire bus slave front end of a 256 byte memory
`timescale 1ns/1ps
`include "sebf_params.svh"

// Summary of operation
// - first byte after start is the address; upper nibble must equal type code
// - address bits 3..1 compare with chip-select pins 2..0, high is one
// - address byte arrives most significant bit first, direction bit last
// - address bit 0 set means read from device, clear means write
// - data line changes only while clock is low
// - data line change while clock is high is a control condition
// - bus is idle while both lines stay high; bus_idle here also needs no transfer open (state idle)
// - data falling with clock high is start; begin address byte
// - data rising with clock high is stop; end current transfer
// - one data bit per clock period, sampled while clock is high
// - works from a stopped clock up to the maximum rate
// - storage is 256 bytes selected by an eight bit word address
// - addressed device pulls data low across the ninth clock high
module sebf_front_end #(
   parameter logic [3:0] DEV_TYPE_CODE = `SEBF_DEV_CODE_DFLT
) (
   input  wire logic  ref_clk,
   input  wire logic  arst_n,
   input  wire logic  scl,
   input  wire logic  sda_in,
   output logic       sda_out,
   output logic       sda_oe,
   input  wire logic  chip_select_pin_0,
   input  wire logic  chip_select_pin_1,
   input  wire logic  chip_select_pin_2,
   output logic       bus_idle,
   output logic       addr_match,
   output logic       xfer_read
);

   sebf_pkg::sebf_ctl_t cur_r;
   sebf_pkg::sebf_ctl_t cur_nxt;

   sebf_bit_if bit_c ();
   sebf_mem_if mem_c ();

   // link side: bits are latched on the master's own clock, any rate
   sebf_bit_capture i_sebf_bit_capture (
      .scl    (scl),
      .arst_n (arst_n),
      .sda_in (sda_in),
      .bit_o  (bit_c.cap)
   );

   sebf_store i_sebf_store (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .mem     (mem_c.store)
   );

   // decoded bus events, all from synchronised levels
   logic       scl_high;
   logic       start_ev;
   logic       stop_ev;
   logic       scl_fall;
   logic       bit_ev;
   logic [7:0] byte_in;
   logic       code_ok;
   logic       cs_ok;

   // a condition needs the clock high before and after the data edge
   always_comb begin
      scl_high = cur_r.scl_s2 & cur_r.scl_d;
      start_ev = scl_high & cur_r.sda_d & ~cur_r.sda_s2;
      stop_ev  = scl_high & ~cur_r.sda_d & cur_r.sda_s2;
      scl_fall = cur_r.scl_d & ~cur_r.scl_s2;
      bit_ev   = cur_r.tgl_s2 ^ cur_r.tgl_d;
   end

   // incoming bit lands at the bottom, so b7 ends up on top
   always_comb begin
      byte_in = {cur_r.shift[6:0], bit_c.bit_val};
      code_ok = byte_in[`SEBF_CODE_HI:`SEBF_CODE_LO] == DEV_TYPE_CODE;
      cs_ok   = byte_in[`SEBF_CS_HI:`SEBF_CS_LO] == cur_r.cs_s2;
   end

   // main sequencing; start and stop take precedence over any bit
   always_comb begin
      cur_nxt = cur_r;

      // two flops on every pin before any logic looks at it
      cur_nxt.sda_s1 = sda_in;
      cur_nxt.sda_s2 = cur_r.sda_s1;
      cur_nxt.sda_d  = cur_r.sda_s2;
      cur_nxt.scl_s1 = scl;
      cur_nxt.scl_s2 = cur_r.scl_s1;
      cur_nxt.scl_d  = cur_r.scl_s2;
      cur_nxt.tgl_s1 = bit_c.bit_tgl;
      cur_nxt.tgl_s2 = cur_r.tgl_s1;
      cur_nxt.tgl_d  = cur_r.tgl_s2;
      cur_nxt.cs_s1  = {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
      cur_nxt.cs_s2  = cur_r.cs_s1;
      cur_nxt.mem_we = 1'b0;

      // idle only with no transfer open and both lines high
      cur_nxt.bus_idle = (cur_r.st == sebf_pkg::SEBF_IDLE)
                         & cur_r.sda_s2 & cur_r.scl_s2;

      if (start_ev) begin
         // also covers a repeated start inside a transfer
         cur_nxt.st         = sebf_pkg::SEBF_RX;
         cur_nxt.bit_cnt    = 4'h0;
         cur_nxt.phase      = `SEBF_PH_DEV;
         cur_nxt.ack_on     = 1'b0;
         cur_nxt.sda_oe     = 1'b0;
         cur_nxt.addr_match = 1'b0;
      end else if (stop_ev) begin
         cur_nxt.st         = sebf_pkg::SEBF_IDLE;
         cur_nxt.bit_cnt    = 4'h0;
         cur_nxt.ack_on     = 1'b0;
         cur_nxt.sda_oe     = 1'b0;
         cur_nxt.addr_match = 1'b0;
      end else begin
         case (cur_r.st)
            sebf_pkg::SEBF_IDLE: begin
               // nothing until a start; line stays released
               cur_nxt.sda_oe = 1'b0;
            end

            sebf_pkg::SEBF_RX: begin
               if (bit_ev) begin
                  cur_nxt.shift   = byte_in;
                  cur_nxt.bit_cnt = cur_r.bit_cnt + 4'h1;
                  if (cur_r.bit_cnt == `SEBF_LAST_BIT) begin
                     cur_nxt.st = sebf_pkg::SEBF_ACK;
                     case (cur_r.phase)
                        `SEBF_PH_DEV: begin
                           if (code_ok && cs_ok) begin
                              cur_nxt.addr_match = 1'b1;
                              cur_nxt.rd_sel = byte_in[`SEBF_DIR_BIT];
                           end else begin
                              // silent until the next start
                              cur_nxt.st = sebf_pkg::SEBF_IGNORE;
                           end
                        end
                        `SEBF_PH_WADDR: begin
                           cur_nxt.word_addr = byte_in;
                        end
                        default: begin
                           cur_nxt.mem_we    = 1'b1;
                           cur_nxt.mem_wdata = byte_in;
                        end
                     endcase
                  end
               end
            end

            sebf_pkg::SEBF_ACK: begin
               // pull low after the eighth fall, release after the ninth
               if (scl_fall && !cur_r.ack_on) begin
                  cur_nxt.ack_on = 1'b1;
                  cur_nxt.sda_oe = 1'b1;
               end else if (scl_fall) begin
                  cur_nxt.ack_on  = 1'b0;
                  cur_nxt.bit_cnt = 4'h0;
                  if (cur_r.phase == `SEBF_PH_DEV && cur_r.rd_sel) begin
                     // first data bit goes out in this same low period
                     cur_nxt.st     = sebf_pkg::SEBF_TX;
                     cur_nxt.shift  = mem_c.rdata;
                     cur_nxt.sda_oe = ~mem_c.rdata[7];
                  end else begin
                     cur_nxt.st     = sebf_pkg::SEBF_RX;
                     cur_nxt.sda_oe = 1'b0;
                     if (cur_r.phase == `SEBF_PH_DATA) begin
                        // page writes wrap inside the low address bits
                        cur_nxt.word_addr[`SEBF_PAGE_BITS-1:0] =
                           cur_r.word_addr[`SEBF_PAGE_BITS-1:0] + 3'h1;
                     end else begin
                        cur_nxt.phase = cur_r.phase + 2'h1;
                     end
                  end
               end
            end

            sebf_pkg::SEBF_TX: begin
               if (bit_ev) begin
                  cur_nxt.bit_cnt = cur_r.bit_cnt + 4'h1;
                  if (cur_r.bit_cnt == `SEBF_LAST_BIT) begin
                     cur_nxt.st        = sebf_pkg::SEBF_TX_ACK;
                     cur_nxt.word_addr = cur_r.word_addr + 8'h01;
                  end
               end else if (scl_fall) begin
                  // next bit changes only while the clock is low
                  cur_nxt.shift  = {cur_r.shift[6:0], 1'b0};
                  cur_nxt.sda_oe = ~cur_r.shift[6];
               end
            end

            sebf_pkg::SEBF_TX_ACK: begin
               if (bit_ev) begin
                  // master acknowledge is the ninth bit, low means more
                  cur_nxt.bit_cnt = cur_r.bit_cnt + 4'h1;
                  cur_nxt.ack_on  = ~bit_c.bit_val;
               end else if (scl_fall && cur_r.bit_cnt == `SEBF_ACK_BIT) begin
                  cur_nxt.sda_oe = 1'b0;
               end else if (scl_fall) begin
                  cur_nxt.ack_on  = 1'b0;
                  cur_nxt.bit_cnt = 4'h0;
                  if (cur_r.ack_on) begin
                     cur_nxt.st     = sebf_pkg::SEBF_TX;
                     cur_nxt.shift  = mem_c.rdata;
                     cur_nxt.sda_oe = ~mem_c.rdata[7];
                  end else begin
                     // not acknowledged: keep the line high for the stop
                     cur_nxt.st     = sebf_pkg::SEBF_IGNORE;
                     cur_nxt.sda_oe = 1'b0;
                  end
               end
            end

            sebf_pkg::SEBF_IGNORE: begin
               cur_nxt.sda_oe = 1'b0;
            end

            default: begin
               cur_nxt.st     = sebf_pkg::SEBF_IDLE;
               cur_nxt.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // control state registered on the reference clock only
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_r           <= '0;
         cur_r.st        <= sebf_pkg::SEBF_IDLE;
         cur_r.sda_s1    <= 1'b1;
         cur_r.sda_s2    <= 1'b1;
         cur_r.sda_d     <= 1'b1;
         cur_r.scl_s1    <= 1'b1;
         cur_r.scl_s2    <= 1'b1;
         cur_r.scl_d     <= 1'b1;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // storage port; address is the running word pointer
   assign mem_c.we    = cur_r.mem_we;
   assign mem_c.addr  = cur_r.word_addr;
   assign mem_c.wdata = cur_r.mem_wdata;

   // open drain: only ever drives low, enable says when
   assign sda_out    = 1'b0;
   assign sda_oe     = cur_r.sda_oe;
   assign bus_idle   = cur_r.bus_idle;
   assign addr_match = cur_r.addr_match;
   assign xfer_read  = cur_r.rd_sel;

endmodule : sebf_front_end

// ===== sebf_front_end_props.sv
// assertion checker on the ports of the bus front end
`timescale 1ns/1ps

module sebf_front_end_props #(
   parameter logic [3:0] DEV_TYPE_CODE = 4'h0
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic chip_select_pin_0,
   input wire logic chip_select_pin_1,
   input wire logic chip_select_pin_2,
   input wire logic bus_idle,
   input wire logic addr_match,
   input wire logic xfer_read
);
   logic [7:0] shf_r; // last eight bits seen at clock rise

   // stands a whole bus period, so sampling it from ref_clk is safe
   always_ff @(posedge scl or negedge arst_n) begin
      if (!arst_n) shf_r <= 8'h00;
      else shf_r <= {shf_r[6:0], sda_in};
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   property p_idle_low; (!scl) [*6] |-> !bus_idle; endproperty
   a_idle_low: assert property (p_idle_low) else $error("idle while clock low");

   property p_stop; $rose(sda_in) && scl && $past(scl) |-> ##[1:6] bus_idle; endproperty
   a_stop: assert property (p_stop) else $error("stop not seen");

   property p_start; $fell(sda_in) && scl && $past(scl) |-> ##[1:6] !(bus_idle || addr_match);
   endproperty
   a_start: assert property (p_start) else $error("start not seen");

   property p_oe_chg; $changed(sda_oe) |-> !scl; endproperty
   a_oe_chg: assert property (p_oe_chg) else $error("data moved with clock high");

   property p_oe_hold; $rose(sda_oe) |-> sda_oe [*8]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("pull too short");

   property p_oe_match; sda_oe |-> addr_match; endproperty
   a_oe_match: assert property (p_oe_match) else $error("drive while unaddressed");

   property p_idle_quiet; bus_idle |-> !(addr_match || sda_oe); endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("busy while idle");

   property p_match_addr;
      $rose(addr_match) |-> shf_r[7:4] == DEV_TYPE_CODE
         && shf_r[3:1] == {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
   endproperty
   a_match_addr: assert property (p_match_addr) else $error("bad match");

   property p_dir; $rose(addr_match) |-> ##[0:2] xfer_read == shf_r[0]; endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
endmodule : sebf_front_end_props

bind sebf_front_end sebf_front_end_props #(.DEV_TYPE_CODE(DEV_TYPE_CODE)) i_sebf_front_end_props (
   .ref_clk(ref_clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_oe(sda_oe),
   .chip_select_pin_0(chip_select_pin_0), .chip_select_pin_1(chip_select_pin_1),
   .chip_select_pin_2(chip_select_pin_2), .bus_idle(bus_idle), .addr_match(addr_match),
   .xfer_read(xfer_read));

// ===== sebf_front_end_test.sv
// self-checking bench for the bus front end with a master model
`timescale 1ns/1ps

module sebf_front_end_test;
   localparam logic [3:0] dc = 4'h9; // type code, value is arbitrary
   logic       ref_clk   = 1'b0;
   logic       arst_n    = 1'b0;
   logic [2:0] cs        = 3'h0;
   logic       scl, sda_drv, sda_w, sda_out, sda_oe, bus_idle, addr_match, xfer_read, a;
   logic [7:0] d;
   int         err_count = 0;
   int         n_checks  = 0;
   int         cyc       = 0;

   // open drain with pull-up: low if anyone pulls
   assign sda_w = sda_drv & (sda_oe ? sda_out : 1'b1);

   always #5 ref_clk = ~ref_clk;

   sebf_front_end #(.DEV_TYPE_CODE(dc)) i_sebf_front_end (
      .ref_clk(ref_clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]),
      .chip_select_pin_2(cs[2]), .bus_idle(bus_idle), .addr_match(addr_match),
      .xfer_read(xfer_read));
   sebf_master_model i_sebf_master_model (.scl(scl), .sda_drv(sda_drv), .sda(sda_w));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test

   // straps change only while idle, then settle through the syncs
   task automatic set_cs(input logic [2:0] v);
      @(posedge ref_clk) cs <= v;
      repeat (5) @(posedge ref_clk);
   endtask : set_cs

   task automatic t_reset();
      repeat (4) @(negedge ref_clk);
      check(bus_idle, 1'b1);
      check({addr_match, sda_oe}, 2'h0);
   endtask : t_reset

   // page write: 07 then wraps to 00
   task automatic t_write();
      set_cs(3'h5);
      i_sebf_master_model.st();
      i_sebf_master_model.wr({dc, 3'h5, 1'b0}, a);
      check({a, addr_match, xfer_read}, 3'h2);
      i_sebf_master_model.wr(8'h07, a);
      check(a, 1'b0);
      i_sebf_master_model.wr(8'ha5, a);
      check(a, 1'b0);
      i_sebf_master_model.wr(8'h3c, a);
      check(a, 1'b0);
      i_sebf_master_model.sp();
      check({bus_idle, addr_match}, 2'h2);
   endtask : t_write

   // random read across the top of the array
   task automatic t_read();
      i_sebf_master_model.st();
      i_sebf_master_model.wr({dc, 3'h5, 1'b0}, a);
      i_sebf_master_model.wr(8'hff, a);
      i_sebf_master_model.st();
      i_sebf_master_model.wr({dc, 3'h5, 1'b1}, a);
      check({a, xfer_read}, 2'h1);
      i_sebf_master_model.rd(1'b0, d);
      check(d, 8'hff);
      i_sebf_master_model.rd(1'b1, d);
      check(d, 8'h3c);
      i_sebf_master_model.sp();
   endtask : t_read

   // partial byte, long clock stall, then restart
   task automatic t_restart();
      i_sebf_master_model.st();
      for (int i = 0; i < 3; i++) i_sebf_master_model.bt(1'b1, a);
      repeat (2000) @(posedge ref_clk);
      i_sebf_master_model.st();
      i_sebf_master_model.wr({dc, 3'h5, 1'b0}, a);
      check(a, 1'b0);
      i_sebf_master_model.wr(8'h07, a);
      i_sebf_master_model.st();
      i_sebf_master_model.wr({dc, 3'h5, 1'b1}, a);
      i_sebf_master_model.rd(1'b1, d);
      check(d, 8'ha5);
      i_sebf_master_model.sp();
   endtask : t_restart

   // every strap value, a one-bit miss, then a byte that must be ignored
   task automatic t_cs();
      for (int v = 0; v < 8; v++) begin
         set_cs(v[2:0]);
         i_sebf_master_model.st();
         i_sebf_master_model.wr({dc, v[2:0], 1'b0}, a);
         check(a, 1'b0);
         i_sebf_master_model.st();
         i_sebf_master_model.wr({dc, v[2:0] ^ (3'h1 << (v % 3)), 1'b0}, a);
         check({a, addr_match}, 2'h2);
         i_sebf_master_model.wr({dc, v[2:0], 1'b0}, a);
         check(a, 1'b1);
         i_sebf_master_model.sp();
      end
   endtask : t_cs

   task automatic t_code();
      for (int i = 0; i < 4; i++) begin
         i_sebf_master_model.st();
         i_sebf_master_model.wr({dc ^ (4'h1 << i), 3'h7, 1'b1}, a);
         check(a, 1'b1);
         i_sebf_master_model.sp();
      end
   endtask : t_code

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         finish_test();
      end
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_reset();
      t_write();
      t_read();
      t_restart();
      t_cs();
      t_code();
      finish_test();
   end
endmodule : sebf_front_end_test

// ===== sebf_ifs.sv
// carriers between the front end and its capture and storage modules
`timescale 1ns/1ps

interface sebf_bit_if;
   logic bit_val;
   logic bit_tgl;
   modport cap (output bit_val, output bit_tgl);
   modport ctl (input bit_val, input bit_tgl);
endinterface : sebf_bit_if

interface sebf_mem_if;
   logic       we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctl   (output we, output addr, output wdata, input rdata);
   modport store (input we, input addr, input wdata, output rdata);
endinterface : sebf_mem_if

// ===== sebf_master_model.sv
// two-wire bus master model, clock and open-drain data drive
`timescale 1ns/1ps

module sebf_master_model (
   output logic      scl,
   output logic      sda_drv,
   input  wire logic sda
);
   localparam real q = 31.25; // quarter of the 125 ns bus clock

   // lines released; clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // data moves a quarter into low phase, read at the end of high
   task automatic bt(input logic b, output logic r);
      #(q) sda_drv = b;
      #(q) scl = 1'b1;
      #(2.0 * q) r = sda;
      scl = 1'b0;
   endtask : bt

   // from idle, or a repeated start from clock low
   task automatic st();
      if (!scl) begin
         #(q) sda_drv = 1'b1;
         #(q) scl = 1'b1;
         #(2.0 * q);
      end
      sda_drv = 1'b0;
      #(2.0 * q) scl = 1'b0;
   endtask : st

   // stop, then bus free time before anything new
   task automatic sp();
      #(q) sda_drv = 1'b0;
      #(q) scl = 1'b1;
      #(2.0 * q) sda_drv = 1'b1;
      #(6.0 * q);
   endtask : sp

   task automatic wr(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bt(v[i], r);
      bt(1'b1, ack);
   endtask : wr

   task automatic rd(input logic mack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
      bt(mack, r);
   endtask : rd
endmodule : sebf_master_model

// ===== sebf_params.svh
// constants for the serial memory bus front end
`ifndef SEBF_PARAMS_SVH
`define SEBF_PARAMS_SVH

// address byte layout, most significant bit first on the wire
`define SEBF_CODE_HI      7
`define SEBF_CODE_LO      4
`define SEBF_CS_HI        3
`define SEBF_CS_LO        1
`define SEBF_DIR_BIT      0

// device-type code default, value is arbitrary
`define SEBF_DEV_CODE_DFLT 4'h5

// byte framing: index of the last data bit, and of the acknowledge bit
`define SEBF_LAST_BIT     4'h7
`define SEBF_ACK_BIT      4'h8

// storage shape and erased value
`define SEBF_MEM_DEPTH    256
`define SEBF_MEM_AW       8
`define SEBF_MEM_RESET    8'hff
`define SEBF_PAGE_BITS    3

// byte roles inside one transfer
`define SEBF_PH_DEV       2'h0
`define SEBF_PH_WADDR     2'h1
`define SEBF_PH_DATA      2'h2

`endif

// ===== sebf_pkg.sv
// types shared by the serial memory bus front end
package sebf_pkg;

   // gray coded along idle, receive, acknowledge, transmit, master ack
   typedef enum logic [2:0] {
      SEBF_IDLE   = 3'h0,
      SEBF_RX     = 3'h1,
      SEBF_ACK    = 3'h3,
      SEBF_TX     = 3'h2,
      SEBF_TX_ACK = 3'h6,
      SEBF_IGNORE = 3'h4
   } sebf_state_t;

   typedef struct packed {
      sebf_state_t st;
      logic [3:0]  bit_cnt;
      logic [7:0]  shift;
      logic [1:0]  phase;
      logic        rd_sel;
      logic        ack_on;
      logic [7:0]  word_addr;
      logic        sda_oe;
      logic        sda_s1;
      logic        sda_s2;
      logic        sda_d;
      logic        scl_s1;
      logic        scl_s2;
      logic        scl_d;
      logic        tgl_s1;
      logic        tgl_s2;
      logic        tgl_d;
      logic [2:0]  cs_s1;
      logic [2:0]  cs_s2;
      logic        mem_we;
      logic [7:0]  mem_wdata;
      logic        bus_idle;
      logic        addr_match;
   } sebf_ctl_t;

   typedef struct packed {
      logic val;
      logic tgl;
   } sebf_cap_t;

   typedef struct packed {
      logic [255:0][7:0] mem;
   } sebf_store_t;

endpackage : sebf_pkg

// ===== sebf_store.sv
// byte-wide storage array held in flip-flops
`timescale 1ns/1ps
`include "sebf_params.svh"

module sebf_store (
   input  wire logic  ref_clk,
   input  wire logic  arst_n,
   sebf_mem_if.store  mem
);

   sebf_pkg::sebf_store_t cur_r;
   sebf_pkg::sebf_store_t cur_nxt;

   // one write port, indexed by the word address
   always_comb begin
      cur_nxt = cur_r;
      if (mem.we) begin
         cur_nxt.mem[mem.addr] = mem.wdata;
      end
   end

   // storage starts erased
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_r <= {`SEBF_MEM_DEPTH{`SEBF_MEM_RESET}};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign mem.rdata = cur_r.mem[mem.addr];

endmodule : sebf_store
